// ==== core/cgs_serial_regs.sv ====
// serial port slave and front register bank of the clock generator
`timescale 1ns/1ps
`include "cgs_defines.svh"

module cgs_serial_regs #(
  parameter logic [7:0] PART_IDENTIFIER = 8'h5A // arbitrary identification value
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  input wire logic io_update_i,
  input wire logic i2c_mode_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic soft_reset_o,
  output logic [7:0] charge_pump_ctrl_o,
  output logic [15:0] cust_version_o
);
  import cgs_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic s_sclk;
  logic s_cs_n;
  logic s_sdio;
  logic s_upd;
  logic s_i2c;

  cgs_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h02)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({i2c_mode_i, io_update_i, sdio_i, cs_n_i, sclk_i}),
    .sync_o({s_i2c, s_upd, s_sdio, s_cs_n, s_sclk})
  );

  // ****************************************************************
  // state and decode helpers
  // ****************************************************************
  cgs_state_s q;
  cgs_state_s next_q;
  logic sclk_rise;
  logic sclk_fall;
  logic upd_rise;
  logic [15:0] instr_shift;
  logic [7:0] data_shift;
  logic [7:0] rd_data;
  logic [7:0] tx_byte;
  logic tx_bit;
  logic wr_fire;
  logic [7:0] wr_byte;

  assign sclk_rise = s_sclk & ~q.sclk_d;
  assign sclk_fall = ~s_sclk & q.sclk_d;
  assign upd_rise = s_upd & ~q.upd_d;
  assign instr_shift = q.lsb_first ? {s_sdio, q.shreg[15:1]}
                                   : {q.shreg[14:0], s_sdio};
  assign data_shift = q.lsb_first ? {s_sdio, q.shreg[7:1]}
                                  : {q.shreg[6:0], s_sdio};
  // first bit of a read byte comes from the live mux, later bits from shifter
  assign tx_byte = (q.bit_cnt == 4'h0) ? rd_data : q.out_byte;
  assign tx_bit = q.lsb_first ? tx_byte[0] : tx_byte[7];

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  always_comb
  begin
    rd_data = `CGS_BYTE_RESET;
    case (q.addr)
      `CGS_ADDR_CONFIG:
      begin
        if (!s_i2c)
        begin
          rd_data[`CGS_CFG_SDO_HI] = q.sdo_en;
          rd_data[`CGS_CFG_SDO_LO] = q.sdo_en;
          rd_data[`CGS_CFG_LSB_HI] = q.lsb_first;
          rd_data[`CGS_CFG_LSB_LO] = q.lsb_first;
        end
        rd_data[`CGS_CFG_SRST_HI] = q.soft_pend;
        rd_data[`CGS_CFG_SRST_LO] = q.soft_pend;
      end
      `CGS_ADDR_PART_IDENTIFIER: rd_data = PART_IDENTIFIER;
      `CGS_ADDR_READBACK: rd_data[`CGS_RB_ACTIVE_BIT] = q.rb_active;
      `CGS_ADDR_VER_LOW: rd_data = q.rb_active ? q.ver_lo_act
                                                : q.ver_lo_buf;
      `CGS_ADDR_VER_HIGH: rd_data = q.rb_active ? q.ver_hi_act
                                                 : q.ver_hi_buf;
      `CGS_ADDR_CHARGE_PUMP: rd_data = q.rb_active ? q.cp_act : q.cp_buf;
      default: rd_data = `CGS_BYTE_RESET;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_q = q;
    next_q.soft_pulse = 1'b0;
    next_q.sclk_d = s_sclk;
    next_q.upd_d = s_upd;
    wr_fire = 1'b0;
    wr_byte = `CGS_BYTE_RESET;
    if (s_cs_n)
    begin
      next_q.phase = cgs_idle;
      next_q.bit_cnt = 4'h0;
      next_q.sdio_oe_n = 1'b1;
      next_q.sdo_oe_n = 1'b1;
    end
    else
    begin
      case (q.phase)
        cgs_idle:
        begin
          next_q.phase = cgs_instr;
          next_q.bit_cnt = 4'h0;
        end
        cgs_instr:
        begin
          if (sclk_rise)
          begin
            next_q.shreg = instr_shift;
            if (q.bit_cnt == `CGS_INSTR_LAST)
            begin
              next_q.rd = instr_shift[`CGS_INSTR_READ_BIT];
              next_q.addr = instr_shift[`CGS_INSTR_ADDR_MSB:0];
              next_q.phase = cgs_data;
              next_q.bit_cnt = 4'h0;
            end
            else
            begin
              next_q.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        cgs_data:
        begin
          if (sclk_rise)
          begin
            next_q.shreg = {8'h00, data_shift};
            if (q.bit_cnt == `CGS_BYTE_LAST)
            begin
              next_q.bit_cnt = 4'h0;
              // streaming walks up in lsb-first mode, down otherwise
              next_q.addr = q.lsb_first ? q.addr + 13'h0001
                                        : q.addr - 13'h0001;
              wr_fire = ~q.rd;
              wr_byte = data_shift;
            end
            else
            begin
              next_q.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
          if (sclk_fall && q.rd)
          begin
            next_q.out_byte = q.lsb_first ? {1'b0, tx_byte[7:1]}
                                          : {tx_byte[6:0], 1'b0};
            if (q.sdo_en)
            begin
              next_q.sdo_o = tx_bit;
              next_q.sdo_oe_n = 1'b0;
            end
            else
            begin
              next_q.sdio_o = tx_bit;
              next_q.sdio_oe_n = 1'b0;
            end
          end
        end
        default: next_q.phase = cgs_idle;
      endcase
    end

    if (wr_fire)
    begin
      case (q.addr)
        `CGS_ADDR_CONFIG:
        begin
          // in i2c mode the mirrored port options do not exist
          next_q.sdo_en = ~s_i2c & (wr_byte[`CGS_CFG_SDO_HI]
                                    | wr_byte[`CGS_CFG_SDO_LO]);
          next_q.lsb_first = ~s_i2c & (wr_byte[`CGS_CFG_LSB_HI]
                                       | wr_byte[`CGS_CFG_LSB_LO]);
          if (wr_byte[`CGS_CFG_SRST_HI] | wr_byte[`CGS_CFG_SRST_LO])
          begin
            next_q.soft_pend = 1'b1;
          end
        end
        `CGS_ADDR_READBACK: next_q.rb_active = wr_byte[`CGS_RB_ACTIVE_BIT];
        `CGS_ADDR_VER_LOW: next_q.ver_lo_buf = wr_byte;
        `CGS_ADDR_VER_HIGH: next_q.ver_hi_buf = wr_byte;
        `CGS_ADDR_CHARGE_PUMP: next_q.cp_buf = wr_byte;
        default: next_q.rd = q.rd;
      endcase
    end

    if (upd_rise)
    begin
      next_q.ver_lo_act = q.ver_lo_buf;
      next_q.ver_hi_act = q.ver_hi_buf;
      next_q.cp_act = q.cp_buf;
    end

    // soft reset lands one cycle after the write and then clears itself
    if (q.soft_pend)
    begin
      next_q.soft_pend = 1'b0;
      next_q.soft_pulse = 1'b1;
      next_q.sdo_en = 1'b0;
      next_q.lsb_first = 1'b0;
      next_q.rb_active = 1'b0;
      next_q.ver_lo_buf = `CGS_BYTE_RESET;
      next_q.ver_hi_buf = `CGS_BYTE_RESET;
      next_q.cp_buf = `CGS_CP_RESET;
      next_q.ver_lo_act = `CGS_BYTE_RESET;
      next_q.ver_hi_act = `CGS_BYTE_RESET;
      next_q.cp_act = `CGS_CP_RESET;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      q <= '0;
      q.phase <= cgs_idle;
      q.cp_buf <= `CGS_CP_RESET;
      q.cp_act <= `CGS_CP_RESET;
      q.sdio_oe_n <= 1'b1;
      q.sdo_oe_n <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign sdio_o = q.sdio_o;
  assign sdio_oe_n_o = q.sdio_oe_n;
  assign sdo_o = q.sdo_o;
  assign sdo_oe_n_o = q.sdo_oe_n;
  assign soft_reset_o = q.soft_pulse;
  assign charge_pump_ctrl_o = q.cp_act;
  assign cust_version_o = {q.ver_hi_act, q.ver_lo_act};

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_outside_ignored: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (wr_fire && q.addr > `CGS_ADDR_CHARGE_PUMP && !q.soft_pend)
    |=> ($stable(q.cp_buf) && $stable(q.ver_lo_buf) && $stable(q.ver_hi_buf)
         && $stable(q.rb_active) && $stable(q.sdo_en) && !q.soft_pend))
    else $error("write outside map changed state");

  a_unused_ignored: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (wr_fire && !q.soft_pend && (q.addr == `CGS_ADDR_UNUSED_A
     || (q.addr >= `CGS_ADDR_UNUSED_LO && q.addr <= `CGS_ADDR_UNUSED_HI)))
    |=> ($stable(q.cp_buf) && $stable(q.ver_lo_buf) && $stable(q.ver_hi_buf)
         && $stable(q.rb_active) && $stable(q.lsb_first)))
    else $error("write to unused address changed state");

  a_spi_mirror: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!s_i2c && q.addr == `CGS_ADDR_CONFIG)
    |-> (rd_data[7] == rd_data[0] && rd_data[6] == rd_data[1]
         && rd_data[5] == rd_data[2] && rd_data[4:3] == 2'b00))
    else $error("config byte pairs not mirrored");

  a_i2c_config: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_i2c && q.addr == `CGS_ADDR_CONFIG)
    |-> ((rd_data & `CGS_I2C_CFG_MASK) == 8'h00))
    else $error("i2c config shows unused bits");

  a_soft_clear: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (wr_fire && q.addr == `CGS_ADDR_CONFIG && (wr_byte[5] || wr_byte[2]))
    |=> q.soft_pend ##1 (!q.soft_pend && q.soft_pulse
                         && q.cp_buf == `CGS_CP_RESET && q.ver_lo_act == 8'h00))
    else $error("soft reset did not restore and clear");

  a_readback_sel: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (q.addr == `CGS_ADDR_CHARGE_PUMP)
    |-> (rd_data == (q.rb_active ? q.cp_act : q.cp_buf)))
    else $error("readback picked wrong bank");

  a_version_write: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (wr_fire && !q.soft_pend && q.addr == `CGS_ADDR_VER_HIGH)
    |=> (q.ver_hi_buf == $past(wr_byte) && $stable(q.ver_lo_buf)))
    else $error("version high byte not stored");

  a_update_copy: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (upd_rise && !q.soft_pend)
    |=> (q.cp_act == $past(q.cp_buf) && q.ver_lo_act == $past(q.ver_lo_buf)))
    else $error("update did not copy buffer");

  a_active_hold: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!upd_rise && !q.soft_pend) |=> ($stable(q.cp_act) && $stable(q.ver_hi_act)))
    else $error("active bank moved without update");

  a_part_identifier_fixed: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (q.addr == `CGS_ADDR_PART_IDENTIFIER) |-> (rd_data == PART_IDENTIFIER))
    else $error("part identifier not fixed");

endmodule : cgs_serial_regs

// ==== core/cgs_defines.svh ====
// address map, field positions and reset values of the serial config bank
`ifndef CGS_DEFINES_SVH
`define CGS_DEFINES_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define CGS_ADDR_CONFIG 13'h0000
`define CGS_ADDR_UNUSED_A 13'h0001
`define CGS_ADDR_RESERVED 13'h0002
`define CGS_ADDR_PART_IDENTIFIER 13'h0003
`define CGS_ADDR_READBACK 13'h0004
`define CGS_ADDR_VER_LOW 13'h0005
`define CGS_ADDR_VER_HIGH 13'h0006
`define CGS_ADDR_UNUSED_LO 13'h0007
`define CGS_ADDR_UNUSED_HI 13'h000F
`define CGS_ADDR_CHARGE_PUMP 13'h0010

// ****************************************************************
// field positions
// ****************************************************************
`define CGS_CFG_SDO_HI 7
`define CGS_CFG_LSB_HI 6
`define CGS_CFG_SRST_HI 5
`define CGS_CFG_SRST_LO 2
`define CGS_CFG_LSB_LO 1
`define CGS_CFG_SDO_LO 0
`define CGS_RB_ACTIVE_BIT 0
`define CGS_INSTR_READ_BIT 15
`define CGS_INSTR_ADDR_MSB 12
`define CGS_I2C_CFG_MASK 8'hDB

// ****************************************************************
// reset values and serial counts
// ****************************************************************
`define CGS_BYTE_RESET 8'h00
`define CGS_CP_RESET 8'h7D
`define CGS_INSTR_LAST 4'hF
`define CGS_BYTE_LAST 4'h7

`endif

// ==== core/cgs_pkg.sv ====
// types shared by the serial config bank
package cgs_pkg;

  typedef enum logic [1:0] {
    cgs_idle = 2'b00,
    cgs_instr = 2'b01,
    cgs_data = 2'b10
  } cgs_phase_e;

  typedef struct packed {
    cgs_phase_e phase;
    logic [3:0] bit_cnt;
    logic [15:0] shreg;
    logic rd;
    logic [12:0] addr;
    logic sdo_en;
    logic lsb_first;
    logic soft_pend;
    logic soft_pulse;
    logic rb_active;
    logic [7:0] ver_lo_buf;
    logic [7:0] ver_hi_buf;
    logic [7:0] cp_buf;
    logic [7:0] ver_lo_act;
    logic [7:0] ver_hi_act;
    logic [7:0] cp_act;
    logic [7:0] out_byte;
    logic sdio_o;
    logic sdio_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
    logic sclk_d;
    logic upd_d;
  } cgs_state_s;

endpackage : cgs_pkg

// ==== core/cgs_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module cgs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cgs_sync_s;

  cgs_sync_s q;
  cgs_sync_s next_q;

  always_comb
  begin
    next_q.meta = async_i;
    next_q.stable = q.meta;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      q <= {RESET_VAL, RESET_VAL};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign sync_o = q.stable;

endmodule : cgs_sync

// ==== bench/cgs_host_model.sv ====
// host side serial master that frames transfers into the config bank
`timescale 1ns/1ps

module cgs_host_model (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o,
  output logic drv_o
);
  // ****************************************************************
  // idle pins: clock stands low outside frames
  // ****************************************************************
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
    drv_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : hold

  // ****************************************************************
  // one frame: instruction then n bytes; first byte in the top of wd/rd
  // ****************************************************************
  task automatic frame(input logic lsb, input logic [15:0] ins,
                       input int n, input logic [15:0] wd,
                       output logic [15:0] rd);
    int k;
    int b;
    int j;
    int idx;
    rd = '0;
    @(negedge sys_clk_i);
    cs_n_o = 1'b0;
    drv_o = 1'b1;
    hold(4);
    for (k = 0; k < 16 + 8 * n; k++)
    begin
      b = (k - 16) / 8;
      j = (k - 16) % 8;
      idx = lsb ? (8 - 8 * b + j) : (15 - 8 * b - j);
      sclk_o = 1'b0;
      // slow phases: every level lasts 4 system cycles
      if (k < 16)
        sdio_o = lsb ? ins[k] : ins[15-k];
      else
        sdio_o = wd[idx];
      drv_o = !(ins[15] && k >= 16);
      hold(4);
      if (k >= 16)
        rd[idx] = line_i;
      sclk_o = 1'b1;
      hold(4);
    end
    sclk_o = 1'b0;
    hold(2);
    cs_n_o = 1'b1;
    drv_o = 1'b0;
    hold(8);
  endtask : frame
endmodule : cgs_host_model

// ==== bench/clock_gen_serial_config_regs_tb.sv ====
// self-checking bench for the serial config register bank
`timescale 1ns/1ps

module clock_gen_serial_config_regs_tb;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identification value
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic io_update_i = 1'b0;
  logic i2c_mode_i = 1'b0;
  logic sclk, cs_n, h_sdio, h_drv, idle_t, line, sdio_w;
  logic d_sdio, d_sdio_oe_n, d_sdo, d_sdo_oe_n, soft_rst;
  logic [7:0] cp;
  logic [15:0] ver;
  logic [15:0] r;
  int err_total = 0;
  int n_compared = 0;
  int pulses = 0;
  int sdo_seen = 0;

  initial
  begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // released wire never repeats the last level
  always @(posedge sys_clk_i) idle_t <= (idle_t === 1'b1) ? 1'b0 : 1'b1;
  always @(posedge sys_clk_i) if (soft_rst === 1'b1) pulses++;
  always @(posedge sys_clk_i) if (d_sdo_oe_n === 1'b0) sdo_seen++;
  assign sdio_w = !d_sdio_oe_n ? d_sdio : (h_drv ? h_sdio : idle_t);
  assign line = !d_sdo_oe_n ? d_sdo : sdio_w;

  cgs_serial_regs #(.PART_IDENTIFIER(ID)) uut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdio_i(sdio_w), .io_update_i(io_update_i),
    .i2c_mode_i(i2c_mode_i), .sdio_o(d_sdio), .sdio_oe_n_o(d_sdio_oe_n),
    .sdo_o(d_sdo), .sdo_oe_n_o(d_sdo_oe_n), .soft_reset_o(soft_rst),
    .charge_pump_ctrl_o(cp), .cust_version_o(ver)
  );

  cgs_host_model host (
    .sys_clk_i(sys_clk_i), .line_i(line), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdio_o(h_sdio), .drv_o(h_drv)
  );

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic l, input logic [12:0] a,
                    input int n, input logic [15:0] d);
    host.frame(l, {3'b000, a}, n, d, r);
  endtask : wr

  task automatic rd(input logic l, input logic [12:0] a, input int n);
    host.frame(l, {3'b100, a}, n, 16'h0000, r);
  endtask : rd

  task automatic update();
    @(negedge sys_clk_i);
    io_update_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    io_update_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
  endtask : update

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk({8'h00, cp}, 16'h007D);
    chk(ver, 16'h0000);
    rd(1'b0, 13'h0000, 1);
    chk(r, 16'h0000);
    rd(1'b0, 13'h0003, 1);
    chk(r, {ID, 8'h00});
    rd(1'b0, 13'h0004, 1);
    chk(r, 16'h0000);
  endtask : t_reset

  task automatic t_update();
    wr(1'b0, 13'h0010, 1, 16'hAB00);
    wr(1'b0, 13'h0006, 2, 16'hC4_93);
    chk({8'h00, cp}, 16'h007D);
    chk(ver, 16'h0000);
    update();
    chk({8'h00, cp}, 16'h00AB);
    chk(ver, 16'hC493);
    wr(1'b0, 13'h0010, 1, 16'h1100);
    rd(1'b0, 13'h0010, 1);
    chk(r, 16'h1100);
    wr(1'b0, 13'h0004, 1, 16'h0100);
    rd(1'b0, 13'h0004, 1);
    chk(r, 16'h0100);
    rd(1'b0, 13'h0010, 1);
    chk(r, 16'hAB00);
    wr(1'b0, 13'h0004, 1, 16'h0000);
  endtask : t_update

  task automatic t_refused();
    logic [12:0] bad[7] = '{13'h0001, 13'h0002, 13'h0003, 13'h0007,
                            13'h000F, 13'h0011, 13'h1FFF};
    foreach (bad[i]) wr(1'b0, bad[i], 1, 16'hFF00);
    rd(1'b0, 13'h0001, 1);
    chk(r, 16'h0000);
    rd(1'b0, 13'h0003, 1);
    chk(r, {ID, 8'h00});
    // msb-first streaming walks down, so the second byte is 0x003
    rd(1'b0, 13'h0004, 2);
    chk(r, {8'h00, ID});
    update();
    chk({8'h00, cp}, 16'h0011);
    chk(ver, 16'hC493);
  endtask : t_refused

  task automatic t_config();
    int p;
    wr(1'b0, 13'h0000, 1, 16'h8000);
    rd(1'b0, 13'h0000, 1);
    chk(r, 16'h8100);
    chk(16'(sdo_seen > 0), 16'h0001);
    wr(1'b0, 13'h0000, 1, 16'h0200);
    rd(1'b1, 13'h0000, 1);
    chk(r, 16'h4200);
    wr(1'b1, 13'h0005, 2, 16'h5A_E1);
    rd(1'b1, 13'h0005, 2);
    chk(r, 16'h5AE1);
    p = pulses;
    wr(1'b1, 13'h0000, 1, 16'h0400);
    chk(16'(pulses - p), 16'h0001);
    chk({8'h00, cp}, 16'h007D);
    chk(ver, 16'h0000);
    rd(1'b0, 13'h0000, 1);
    chk(r, 16'h0000);
    rd(1'b0, 13'h0005, 1);
    chk(r, 16'h0000);
  endtask : t_config

  task automatic t_i2c();
    int p;
    @(negedge sys_clk_i);
    i2c_mode_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    wr(1'b0, 13'h0000, 1, 16'hC300);
    rd(1'b0, 13'h0000, 1);
    chk(r, 16'h0000);
    p = pulses;
    wr(1'b0, 13'h0000, 1, 16'h2000);
    chk(16'(pulses - p), 16'h0001);
    @(negedge sys_clk_i);
    i2c_mode_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
  endtask : t_i2c

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (10) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    t_reset();
    t_update();
    t_refused();
    t_config();
    t_i2c();
    conclude();
  end
endmodule : clock_gen_serial_config_regs_tb
